// file: rtl/ppx_pkg.sv
// package for the parallel port extended control register block
`default_nettype none
package ppx_pkg;
  localparam logic [9:0] PPX_OFS_CFG_A = 10'h400;
  localparam logic [9:0] PPX_OFS_CFG_B = 10'h401;
  localparam logic [9:0] PPX_OFS_ECR = 10'h402;
  localparam logic [7:0] PPX_CFG_A_VAL = 8'h10;
  localparam int PPX_MODE_HI = 7;
  localparam int PPX_MODE_LO = 5;
  localparam int PPX_FLT_BIT = 4;
  localparam int PPX_DMA_BIT = 3;
  localparam int PPX_SVC_BIT = 2;
  localparam int PPX_FULL_BIT = 1;
  localparam int PPX_EMPTY_BIT = 0;
  localparam int PPX_IRQ_LO = 3;
  localparam int PPX_IRQ_HI = 5;
  localparam int PPX_INTV_BIT = 6;
  localparam logic [4:0] PPX_ECR_RST = 5'h14;
  localparam logic [1:0] PPX_PULSE_CYC = 2'h3;

  typedef enum logic [2:0] {
    PPX_M_SPP = 3'b000,
    PPX_M_PS2 = 3'b001,
    PPX_M_FIFO = 3'b010,
    PPX_M_ECP = 3'b011,
    PPX_M_EPP = 3'b100,
    PPX_M_RSVD = 3'b101,
    PPX_M_TEST = 3'b110,
    PPX_M_CFG = 3'b111
  } ppx_mode_t;

  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ppx_bus_t;

  typedef struct packed {
    logic [7:0] free_cnt;
    logic [7:0] fill_cnt;
    logic full;
    logic empty;
  } ppx_fifo_t;
endpackage : ppx_pkg
`default_nettype wire

// file: rtl/ppx_ecr.sv
// extended control register of the multi-mode parallel port
`default_nettype none
module ppx_ecr
  import ppx_pkg::*;
#(
  parameter logic [7:0] TX_FREE_LEVEL = 8'h08,
  parameter logic [7:0] RX_FILL_LEVEL = 8'h08
) (
  input wire logic clk,
  input wire logic rst,
  input wire ppx_bus_t bus,
  output logic [7:0] rdata,
  output logic rdata_hit,
  input wire ppx_fifo_t fifo,
  input wire logic fault_input_n,
  input wire logic dma_tc,
  input wire logic dir_bit,
  input wire logic [3:0] irq_channel,
  input wire logic epp_option_en,
  input wire logic irq_line_in,
  output logic [2:0] mode,
  output logic fifo_reset,
  output logic fifo_tx_std,
  output logic fifo_tx_ecp,
  output logic fifo_rx_ecp,
  output logic fifo_host_only,
  output logic epp_active,
  output logic cfg_regs_mapped,
  output logic data_read_pins,
  output logic data_out_en,
  output logic ctrl_push_pull,
  output logic dma_req_en,
  output logic irq_out,
  output logic irq_oe
);
  logic [2:0] mode_ff;
  logic fault_irq_disable_ff;
  logic transfer_engine_enable_ff;
  logic service_irq_mask_ff;
  logic fault_prev_ff;
  logic [1:0] pulse_cnt_ff;
  logic [2:0] irq_code;
  logic wr_ecr;
  logic svc_cond;
  logic svc_fire;
  logic flt_fire;
  logic dir_eff;
  logic dir_free;
  ppx_mode_t mode_q;
  logic [7:0] cfg_b;
  logic [7:0] nxt_rdata;
  logic nxt_rdata_hit;

  assign wr_ecr = bus.wr && (bus.addr == PPX_OFS_ECR);

  always_comb begin
    unique case (irq_channel)
      4'hF: irq_code = 3'h6;
      4'hE: irq_code = 3'h5;
      4'hB: irq_code = 3'h4;
      4'hA: irq_code = 3'h3;
      4'h9: irq_code = 3'h2;
      4'h7: irq_code = 3'h1;
      4'h5: irq_code = 3'h7;
      default: irq_code = 3'h0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_ff <= PPX_M_SPP;
      fault_irq_disable_ff <= PPX_ECR_RST[PPX_FLT_BIT];
      transfer_engine_enable_ff <= PPX_ECR_RST[PPX_DMA_BIT];
    end else if (wr_ecr) begin
      mode_ff <= bus.wdata[PPX_MODE_HI:PPX_MODE_LO];
      fault_irq_disable_ff <= bus.wdata[PPX_FLT_BIT];
      transfer_engine_enable_ff <= bus.wdata[PPX_DMA_BIT];
    end
  end

  // service condition per dma/direction case
  always_comb begin
    if (transfer_engine_enable_ff)
      svc_cond = dma_tc;
    else if (!dir_eff)
      svc_cond = fifo.free_cnt >= TX_FREE_LEVEL;
    else
      svc_cond = fifo.fill_cnt >= RX_FILL_LEVEL;
  end

  // level conditions fire at once when bit 2 is cleared, so none are missed
  assign svc_fire = !service_irq_mask_ff && svc_cond;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      service_irq_mask_ff <= PPX_ECR_RST[PPX_SVC_BIT];
    end else if (svc_fire) begin
      service_irq_mask_ff <= 1'b1;
    end else if (wr_ecr) begin
      service_irq_mask_ff <= bus.wdata[PPX_SVC_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_prev_ff <= 1'b1;
    end else begin
      fault_prev_ff <= fault_input_n;
    end
  end

  assign flt_fire = (mode_ff == PPX_M_ECP) && !fault_input_n &&
    ((!fault_irq_disable_ff && fault_prev_ff) ||
     (wr_ecr && fault_irq_disable_ff && !bus.wdata[PPX_FLT_BIT]));

  // short low pulse, then released for a shared line
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pulse_cnt_ff <= 2'h0;
    end else if (svc_fire || flt_fire) begin
      pulse_cnt_ff <= PPX_PULSE_CYC;
    end else if (pulse_cnt_ff != 2'h0) begin
      pulse_cnt_ff <= pulse_cnt_ff - 2'h1;
    end
  end

  assign irq_out = 1'b0;
  assign irq_oe = pulse_cnt_ff != 2'h0;

  assign mode = mode_ff;
  assign mode_q = ppx_mode_t'(mode_ff);
  assign dir_eff = dir_bit && dir_free;
  assign data_out_en = !dir_eff;

  // every signal of this case spelled out per mode, so no mode inherits another's drive
  always_comb begin
    unique case (mode_q)
      PPX_M_SPP: begin
        fifo_reset = 1'b1;
        fifo_tx_std = 1'b0;
        fifo_tx_ecp = 1'b0;
        fifo_rx_ecp = 1'b0;
        fifo_host_only = 1'b0;
        epp_active = 1'b0;
        cfg_regs_mapped = 1'b0;
        data_read_pins = 1'b0;
        ctrl_push_pull = 1'b0;
        dir_free = 1'b0;
      end
      PPX_M_PS2: begin
        fifo_reset = 1'b0;
        fifo_tx_std = 1'b0;
        fifo_tx_ecp = 1'b0;
        fifo_rx_ecp = 1'b0;
        fifo_host_only = 1'b0;
        epp_active = 1'b0;
        cfg_regs_mapped = 1'b0;
        data_read_pins = 1'b1;
        ctrl_push_pull = 1'b1;
        dir_free = 1'b1;
      end
      PPX_M_FIFO: begin
        fifo_reset = 1'b0;
        fifo_tx_std = 1'b1;
        fifo_tx_ecp = 1'b0;
        fifo_rx_ecp = 1'b0;
        fifo_host_only = 1'b0;
        epp_active = 1'b0;
        cfg_regs_mapped = 1'b0;
        data_read_pins = 1'b1;
        ctrl_push_pull = 1'b1;
        dir_free = 1'b0;
      end
      PPX_M_ECP: begin
        fifo_reset = 1'b0;
        fifo_tx_std = 1'b0;
        fifo_tx_ecp = !dir_bit;
        fifo_rx_ecp = dir_bit;
        fifo_host_only = 1'b0;
        epp_active = 1'b0;
        cfg_regs_mapped = 1'b0;
        data_read_pins = 1'b1;
        ctrl_push_pull = 1'b1;
        dir_free = 1'b1;
      end
      PPX_M_EPP: begin
        fifo_reset = 1'b0;
        fifo_tx_std = 1'b0;
        fifo_tx_ecp = 1'b0;
        fifo_rx_ecp = 1'b0;
        fifo_host_only = 1'b0;
        epp_active = epp_option_en;
        cfg_regs_mapped = 1'b0;
        data_read_pins = 1'b1;
        ctrl_push_pull = 1'b1;
        dir_free = 1'b1;
      end
      PPX_M_RSVD: begin
        // reserved code behaves as a plain push-pull port
        fifo_reset = 1'b0;
        fifo_tx_std = 1'b0;
        fifo_tx_ecp = 1'b0;
        fifo_rx_ecp = 1'b0;
        fifo_host_only = 1'b0;
        epp_active = 1'b0;
        cfg_regs_mapped = 1'b0;
        data_read_pins = 1'b1;
        ctrl_push_pull = 1'b1;
        dir_free = 1'b1;
      end
      PPX_M_TEST: begin
        fifo_reset = 1'b0;
        fifo_tx_std = 1'b0;
        fifo_tx_ecp = 1'b0;
        fifo_rx_ecp = 1'b0;
        fifo_host_only = 1'b1;
        epp_active = 1'b0;
        cfg_regs_mapped = 1'b0;
        data_read_pins = 1'b1;
        ctrl_push_pull = 1'b1;
        dir_free = 1'b1;
      end
      PPX_M_CFG: begin
        fifo_reset = 1'b0;
        fifo_tx_std = 1'b0;
        fifo_tx_ecp = 1'b0;
        fifo_rx_ecp = 1'b0;
        fifo_host_only = 1'b0;
        epp_active = 1'b0;
        cfg_regs_mapped = 1'b1;
        data_read_pins = 1'b1;
        ctrl_push_pull = 1'b1;
        dir_free = 1'b1;
      end
    endcase
  end

  assign dma_req_en = transfer_engine_enable_ff &&
    !service_irq_mask_ff;

  always_comb begin
    cfg_b = 8'h00;
    cfg_b[PPX_IRQ_HI:PPX_IRQ_LO] = irq_code;
    cfg_b[PPX_INTV_BIT] = irq_line_in;
  end

  // unmapped reads return zero so a stale byte never leaks out
  always_comb begin
    nxt_rdata = 8'h00;
    nxt_rdata_hit = 1'b0;
    if (bus.rd && bus.addr == PPX_OFS_ECR) begin
      nxt_rdata = {mode_ff, fault_irq_disable_ff, transfer_engine_enable_ff,
        service_irq_mask_ff, fifo.full, fifo.empty};
      nxt_rdata_hit = 1'b1;
    end else if (bus.rd && cfg_regs_mapped &&
                 bus.addr == PPX_OFS_CFG_A) begin
      nxt_rdata = PPX_CFG_A_VAL;
      nxt_rdata_hit = 1'b1;
    end else if (bus.rd && cfg_regs_mapped &&
                 bus.addr == PPX_OFS_CFG_B) begin
      nxt_rdata = cfg_b;
      nxt_rdata_hit = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
      rdata_hit <= 1'b0;
    end else begin
      rdata <= nxt_rdata;
      rdata_hit <= nxt_rdata_hit;
    end
  end
endmodule : ppx_ecr
`default_nettype wire

// file: test/ppx_ecr_chk.sv
// port checker for the extended control register
`default_nettype none
module ppx_ecr_chk
  import ppx_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire ppx_bus_t bus,
  input wire logic [7:0] rdata,
  input wire logic rdata_hit,
  input wire ppx_fifo_t fifo,
  input wire logic dma_tc,
  input wire logic dir_bit,
  input wire logic [2:0] mode,
  input wire logic fifo_reset,
  input wire logic data_out_en,
  input wire logic ctrl_push_pull,
  input wire logic dma_req_en,
  input wire logic irq_out,
  input wire logic irq_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic ecr_rd;
  assign ecr_rd = bus.rd && bus.addr == PPX_OFS_ECR;
  ecr_read_a: assert property (ecr_rd |=> rdata_hit
    && rdata[7:5] == $past(mode)) else $error("ecr read mode bad");
  flag_bits_a: assert property (ecr_rd |=> rdata[1:0] ==
    {$past(fifo.full), $past(fifo.empty)}) else $error("fifo flags bad");
  miss_read_a: assert property (bus.rd && bus.addr < PPX_OFS_CFG_A
    |=> !rdata_hit && rdata == 8'h00) else $error("unmapped read hit");
  drive_kind_a: assert property (
    ctrl_push_pull == (mode != 3'h0) && fifo_reset == (mode == 3'h0))
    else $error("driver kind bad");
  dir_force_a: assert property (data_out_en ==
    !(dir_bit && mode != 3'h0 && mode != 3'h2)) else $error("dir bad");
  dma_gate_a: assert property (ecr_rd && dma_req_en
    |=> rdata[3:2] == 2'h2) else $error("dma gate bad");
  irq_pulse_a: assert property ($rose(irq_oe)
    |-> (irq_oe && !irq_out)[*3] ##1 !irq_oe) else $error("pulse bad");
  tc_irq_a: assert property (dma_tc && dma_req_en
    |-> ##[1:2] irq_oe) else $error("no irq on tc");
endmodule : ppx_ecr_chk
bind ppx_ecr ppx_ecr_chk u_chk (.*);
`default_nettype wire

// file: test/ppx_peer.sv
// peripheral model: fault pin and dma terminal count
`default_nettype none
module ppx_peer (
  input wire logic clk,
  input wire logic fault_req,
  input wire logic tc_req,
  output logic fault_input_n = 1'b1,
  output logic dma_tc = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  // pin is pulled up, so it idles high until a fault
  always @(posedge clk) fault_input_n <= !fault_req;
  always @(posedge clk) dma_tc <= tc_req;
endmodule : ppx_peer
`default_nettype wire

// file: test/ppx_ecr_tb_top.sv
// self-checking bench for the extended control register
`default_nettype none
`define CK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  err_total++; $display("wrong value t=%0t got %h exp %h", $time, a, e); \
  end end
module ppx_ecr_tb_top;
  import ppx_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst = 1, dir_bit = 0, epp_option_en = 1, irq_line_in = 1;
  logic fault_req = 0, tc_req = 0, fault_input_n, dma_tc, seen;
  logic [3:0] irq_channel = 4'h0;
  ppx_bus_t bus = '0;
  ppx_fifo_t fifo = '{8'h00, 8'h00, 1'b0, 1'b1};
  logic [7:0] rdata, v;
  logic [2:0] mode;
  logic rdata_hit, fifo_reset, fifo_tx_std, fifo_tx_ecp, fifo_rx_ecp;
  logic fifo_host_only, epp_active, cfg_regs_mapped, data_read_pins;
  logic data_out_en, ctrl_push_pull, dma_req_en, irq_out, irq_oe;
  int err_total = 0, samples_checked = 0;
  // row: mode, then rst, push-pull, tx, host, epp, cfg flags
  logic [8:0] rows [8] = '{9'h020, 9'h050, 9'h098, 9'h0D0,
    9'h112, 9'h150, 9'h194, 9'h1D1};
  // channel code, three bits per channel, channel 15 on top
  logic [47:0] codes = 48'hD408D0238000;
  logic [5:0] flags;
  assign flags = {fifo_reset, ctrl_push_pull, fifo_tx_std, fifo_host_only,
    epp_active, cfg_regs_mapped};
  initial forever #4 clk = ~clk;
  ppx_peer peer (.clk(clk), .fault_req(fault_req), .tc_req(tc_req),
    .fault_input_n(fault_input_n), .dma_tc(dma_tc));
  ppx_ecr dut (.*);
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk) #1 bus = '{a, d, 1'b1, 1'b0};
    @(posedge clk) #1 bus.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [9:0] a);
    @(posedge clk) #1 bus = '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) #1 bus.rd = 1'b0;
    v = rdata;
  endtask : rd
  // window covers latency plus the whole pulse
  task automatic irq_chk(input logic e);
    seen = 1'b0;
    repeat (8) @(posedge clk) #1 seen |= irq_oe;
    `CK(seen, e)
  endtask : irq_chk
  task automatic final_report();
    if (err_total == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 0;
    rd(PPX_OFS_ECR);
    `CK(v, 8'h15)
    rd(10'h3FF);
    `CK({rdata_hit, v}, 9'h000)
    dir_bit = 1;
    // flag bits 1:0 written as ones must read back the fifo flags instead
    foreach (rows[i]) begin
      wr(PPX_OFS_ECR, {rows[i][8:6], 5'h17});
      rd(PPX_OFS_ECR);
      `CK(v, {rows[i][8:6], 5'h15})
      `CK(flags, rows[i][5:0])
      `CK(data_read_pins, rows[i][8:6] != 3'h0)
      `CK(data_out_en, (rows[i][8:6] == 3'h0 || rows[i][8:6] == 3'h2))
    end
    rd(PPX_OFS_CFG_A);
    `CK(v, PPX_CFG_A_VAL)
    for (int c = 0; c < 16; c++) begin
      irq_channel = c[3:0];
      rd(PPX_OFS_CFG_B);
      `CK(v[6:3], {1'b1, codes[3*c +: 3]})
    end
    epp_option_en = 0;
    wr(PPX_OFS_ECR, 8'h97);
    `CK(epp_active, 1'b0)
    epp_option_en = 1;
    dir_bit = 0;
    fifo.free_cnt = 8'h07;
    wr(PPX_OFS_ECR, 8'h70);
    `CK({fifo_tx_ecp, fifo_rx_ecp}, 2'h2)
    irq_chk(1'b0);
    fifo.free_cnt = 8'h08;
    irq_chk(1'b1);
    rd(PPX_OFS_ECR);
    `CK(v[2], 1'b1)
    dir_bit = 1;
    fifo = '{8'h00, 8'h08, 1'b1, 1'b0};
    wr(PPX_OFS_ECR, 8'h74);
    `CK({fifo_tx_ecp, fifo_rx_ecp}, 2'h1)
    irq_chk(1'b0);
    wr(PPX_OFS_ECR, 8'h70);
    irq_chk(1'b1);
    rd(PPX_OFS_ECR);
    `CK(v[2:0], 3'h6)
    fifo = '{8'h00, 8'h00, 1'b0, 1'b1};
    wr(PPX_OFS_ECR, 8'h78);
    rd(PPX_OFS_ECR);
    `CK(dma_req_en, 1'b1)
    tc_req = 1;
    @(posedge clk) #1 tc_req = 0;
    irq_chk(1'b1);
    `CK(dma_req_en, 1'b0)
    wr(PPX_OFS_ECR, 8'h64);
    fault_req = 1;
    irq_chk(1'b1);
    wr(PPX_OFS_ECR, 8'h74);
    wr(PPX_OFS_ECR, 8'h64);
    irq_chk(1'b1);
    rst = 1;
    repeat (2) @(posedge clk);
    #1 rst = 0;
    rd(PPX_OFS_ECR);
    `CK(v, 8'h15)
    `CK(fifo_reset, 1'b1)
    final_report();
  end
endmodule : ppx_ecr_tb_top
`default_nettype wire
